// >>> verilog/pwr_seq_pkg.sv
`default_nettype none
package pwr_seq_pkg;
  // Converter data width and sample clock rate
  localparam int unsigned DATA_W        = 12;
  localparam int unsigned CLK_MHZ       = 250;
  // Nap recovery in sample clocks
  localparam int unsigned NAP_RECOV_CYC = 100;
  // Sleep recovery time in microseconds (reference recharge)
  localparam int unsigned SLEEP_RECOV_US = 2000;
  localparam int unsigned SLEEP_RECOV_CYC = SLEEP_RECOV_US * CLK_MHZ;
  localparam int unsigned CNT_W         = 24;

  // Power mode codes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_NAP    = 2'b01,
    MODE_SLEEP  = 2'b10
  } pwr_mode_t;
endpackage : pwr_seq_pkg
`default_nettype wire

// >>> verilog/recov_if.sv
`timescale 1ns/1ps
`default_nettype none
// Recovery timer hand-off between mode control and settle counter
interface recov_if;
  logic                          start;
  logic [pwr_seq_pkg::CNT_W-1:0] load;
  logic                          busy;
  modport ctrl (output start, output load, input busy);
  modport tmr  (input start, input load, output busy);
endinterface : recov_if
`default_nettype wire

// >>> verilog/recov_timer.sv
`timescale 1ns/1ps
`default_nettype none
module recov_timer (
  input  wire logic clk,
  input  wire logic rst,
  recov_if.tmr      rif
);
  typedef struct packed {
    logic [pwr_seq_pkg::CNT_W-1:0] cnt;
  } tmr_state_t;

  tmr_state_t st_q;
  tmr_state_t st_d;

  // Load on start, then count down to zero
  always_comb begin
    st_d = st_q;
    if (rif.start) begin
      st_d.cnt = rif.load;
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rif.busy = (st_q.cnt != '0);
endmodule : recov_timer
`default_nettype wire

// >>> verilog/adc_output_enable_power_modes.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Disable high tri-states data, overrange, clock
// - Select low means normal conversion
// - Select and disable high: sleep
// - Samples invalid milliseconds after sleep exit
// - Select high, disable low: nap
// - Samples invalid 100 cycles after nap
// - Sleep and nap tri-state all outputs
// - Data changes after output clock rises
module adc_output_enable_power_modes #(
  // Word width and recovery lengths in core clocks
  parameter int unsigned DATA_W    = pwr_seq_pkg::DATA_W,
  parameter int unsigned SLEEP_CYC = pwr_seq_pkg::SLEEP_RECOV_CYC,
  parameter int unsigned NAP_CYC   = pwr_seq_pkg::NAP_RECOV_CYC
) (
  // Core clock and asynchronous reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Control pins from the host, taken as synchronous levels
  input  wire logic              out_disable,
  input  wire logic              power_down_select,
  // Converter word and overrange from the pipeline
  input  wire logic [DATA_W-1:0] conv_data,
  input  wire logic              conv_over,
  // Pad drivers and their enables, high while driving
  output logic [DATA_W-1:0]      data_o,
  output logic [DATA_W-1:0]      data_oe,
  output logic                   overrange_flag_o,
  output logic                   overrange_flag_oe,
  output logic                   sample_clock_out_o,
  output logic                   sample_clock_out_oe,
  // Status toward the analog side and the host
  output logic                   reference_on,
  output logic                   core_active,
  output logic                   data_valid
);
  // Whole state of the block, apart from the timer count, in one register
  // Mode is the decoded pin pair of the previous edge, so a wake
  // shows up as a change between the stored and the fresh decode.
  // Pad drivers, their enables and the staged word all live here,
  // so every output comes straight from a flip-flop.
  // The cold flag remembers that the reference was dropped in
  // sleep, until a wake has started the long recovery wait.
  typedef struct packed {
    pwr_seq_pkg::pwr_mode_t mode;
    logic [DATA_W-1:0]      data;
    logic                   over;
    logic                   oe;
    logic                   ckout;
    logic                   ref_on;
    logic                   core_on;
    logic                   valid;
    logic                   ref_cold; // Reference lost since last wake
  } top_state_t;

  // Current and next state; the timer hand-off rides on the
  // interface so the counter can change without port churn.
  top_state_t st_q;
  top_state_t st_d;
  recov_if    rif ();

  // Recovery loads, cut to the timer width on purpose
  // The two millisecond sleep default fits in 24 bits with room.
  // Simulation overrides both with short values to keep runs brief.
  localparam logic [pwr_seq_pkg::CNT_W-1:0] SLEEP_LOAD =
    pwr_seq_pkg::CNT_W'(SLEEP_CYC);
  localparam logic [pwr_seq_pkg::CNT_W-1:0] NAP_LOAD =
    pwr_seq_pkg::CNT_W'(NAP_CYC);

  // Mode from the two pins
  // Select low always wins: the disable pin then only gates pads.
  // Select high splits on the disable pin between sleep and nap.
  function automatic pwr_seq_pkg::pwr_mode_t decode_mode(
    input logic sel,
    input logic dis
  );
    if (!sel) begin
      return pwr_seq_pkg::MODE_NORMAL;
    end else if (dis) begin
      return pwr_seq_pkg::MODE_SLEEP;
    end else begin
      return pwr_seq_pkg::MODE_NAP;
    end
  endfunction : decode_mode

  // True only for normal conversion
  function automatic logic is_normal(input pwr_seq_pkg::pwr_mode_t m);
    return m == pwr_seq_pkg::MODE_NORMAL;
  endfunction : is_normal

  // Recovery length for a wake into normal mode
  // A reference dropped in sleep needs the long wait even when the
  // wake passes through nap first: a short nap is no proof that the
  // reference capacitors have recharged. Trade: a long nap after
  // sleep waits longer than strictly needed.
  function automatic logic [pwr_seq_pkg::CNT_W-1:0] recov_load(
    input pwr_seq_pkg::pwr_mode_t prev,
    input logic                   cold
  );
    if (prev == pwr_seq_pkg::MODE_SLEEP || cold) begin
      return SLEEP_LOAD;
    end else begin
      return NAP_LOAD;
    end
  endfunction : recov_load

  // Shared down counter for both wakes
  // Only one wake can be pending, since another needs a power-down
  // first; a reload mid count just restarts the wait from the top.
  recov_timer u_timer (
    .clk (clk),
    .rst (rst),
    .rif (rif.tmr)
  );

  // Limitations: output mode pins and data format live elsewhere;
  // the word passes through as the pipeline delivers it.
  // The pads have no keeper here, so a released bus floats at the
  // far side unless the board pulls it.

  // Mode tracking, recovery start and output staging
  // Pins are taken as synchronous, so they decode straight into the
  // next state without a synchroniser stage.
  always_comb begin
    pwr_seq_pkg::pwr_mode_t nxt;
    nxt       = decode_mode(power_down_select, out_disable);
    st_d      = st_q;
    rif.start = 1'b0;
    rif.load  = NAP_LOAD;
    st_d.mode = nxt;
    case (nxt)
      pwr_seq_pkg::MODE_NORMAL: begin
        st_d.ref_on  = 1'b1;
        st_d.core_on = 1'b1;
      end
      pwr_seq_pkg::MODE_NAP: begin
        st_d.ref_on  = 1'b1;
        st_d.core_on = 1'b0;
      end
      pwr_seq_pkg::MODE_SLEEP: begin
        st_d.ref_on  = 1'b0;
        st_d.core_on = 1'b0;
      end
      // Unused code: everything off
      default: begin
        st_d.ref_on  = 1'b0;
        st_d.core_on = 1'b0;
      end
    endcase

    // Reference goes cold in sleep and stays so until a wake
    if (nxt == pwr_seq_pkg::MODE_SLEEP) begin
      st_d.ref_cold = 1'b1;
    end

    // wake loads recovery count
    // The wait depends on where the wake came from and on whether
    // the reference was dropped along the way.
    if (!is_normal(st_q.mode) && is_normal(nxt)) begin
      rif.start     = 1'b1;
      rif.load      = recov_load(st_q.mode, st_q.ref_cold);
      st_d.ref_cold = 1'b0;
    end

    // drivers off when disabled or powered down
    // Enable follows the pins one edge late, like every output;
    // slow pad turn-on is why the host must not toggle it per word.
    st_d.oe = !out_disable && is_normal(nxt);

    // output clock rises, data updates with it
    // The output clock runs at half the core clock; the word is
    // staged on the edge that raises it, so it stands two cycles
    // and is steady at the falling edge the host captures on.
    // Data keeps moving while the pads are off; only drive stops.
    st_d.ckout = ~st_q.ckout;
    if (!st_q.ckout) begin
      st_d.data = conv_data;
      st_d.over = conv_over;
    end

    // Valid only while converting and recovered
    // The start term covers the wake edge itself, before the timer
    // shows busy; the mode term blocks the first normal edge.
    // Valid never rises while the pads are off in a low-power mode.
    st_d.valid = is_normal(nxt) && !rif.start &&
                 !rif.busy && is_normal(st_q.mode);
  end

  // State register; reset means normal mode with the pads off
  // Reset assigns a constant only, so no path leaks through it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Pad outputs and status straight from the state register
  // One enable flop fans out to every data pad, so the bus is never
  // left half driven.
  assign data_o              = st_q.data;
  assign data_oe             = {DATA_W{st_q.oe}};
  assign overrange_flag_o    = st_q.over;
  assign overrange_flag_oe   = st_q.oe;
  assign sample_clock_out_o  = st_q.ckout;
  assign sample_clock_out_oe = st_q.oe;
  assign reference_on        = st_q.ref_on;
  assign core_active         = st_q.core_on;
  assign data_valid          = st_q.valid;
endmodule : adc_output_enable_power_modes
`default_nettype wire

// >>> verification/pwr_modes_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pwr_modes_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        out_disable,
  input wire logic        power_down_select,
  input wire logic [11:0] data_oe,
  input wire logic        overrange_flag_oe,
  input wire logic        sample_clock_out_oe,
  input wire logic        reference_on,
  input wire logic        core_active,
  input wire logic        data_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_DIS_OFF: assert property (out_disable |=> data_oe == '0
    && !overrange_flag_oe && !sample_clock_out_oe) else $error("oe on");
  AST_EN_ON: assert property (!out_disable && !power_down_select
    |=> data_oe == '1 && overrange_flag_oe) else $error("oe off");
  AST_NORM: assert property (!power_down_select
    |=> core_active && reference_on) else $error("not normal");
  AST_SLEEP: assert property (power_down_select && out_disable
    |=> !reference_on && !core_active) else $error("not sleep");
  AST_NAP: assert property (power_down_select && !out_disable
    |=> reference_on && !core_active) else $error("not nap");
  AST_PD_HIZ: assert property (power_down_select
    |=> data_oe == '0 && !sample_clock_out_oe) else $error("driving");
  AST_NAP_WAIT: assert property (power_down_select && !out_disable
    ##1 !power_down_select |=> !data_valid[*8] ##[1:4] data_valid)
    else $error("nap recovery");
  AST_SLP_WAIT: assert property (power_down_select && out_disable
    ##1 !power_down_select |=> !data_valid[*8] ##[10:16] data_valid)
    else $error("sleep recovery");
  AST_VALID: assert property (data_valid |-> core_active)
    else $error("valid idle");
endmodule : pwr_modes_assertions
bind adc_output_enable_power_modes pwr_modes_assertions chk_i (
  .clk(clk), .rst(rst), .out_disable(out_disable),
  .power_down_select(power_down_select), .data_oe(data_oe),
  .overrange_flag_oe(overrange_flag_oe),
  .sample_clock_out_oe(sample_clock_out_oe), .reference_on(reference_on),
  .core_active(core_active), .data_valid(data_valid));
`default_nettype wire

// >>> verification/capture_model.sv
`timescale 1ns/1ps
`default_nettype none
module capture_model #(
  parameter int unsigned SETTLE = 2
) (
  input  wire logic        sclk,
  input  wire logic [11:0] data,
  input  wire logic        oe,
  input  wire logic        valid,
  output logic      [11:0] word
);
  logic [3:0] settle_q = 4'h0;
  always @(negedge sclk) begin
    if (!oe)
      settle_q <= 4'(SETTLE);
    else if (settle_q != 4'h0)
      settle_q <= settle_q - 4'h1;
    if (oe && valid && settle_q == 4'h0)
      word <= data;
  end
endmodule : capture_model
`default_nettype wire

// >>> verification/adc_output_enable_power_modes_test.sv
`timescale 1ns/1ps
`default_nettype none
module adc_output_enable_power_modes_test;
  logic        clk = 0, rst = 1, dis = 0, sel = 0, ovr = 0;
  logic [11:0] din = 12'h5a3, d, oe, word;
  logic        sc, sc_oe, ov, ov_oe, ref_on, core, valid;
  int          bad_count = 0, checked = 0, cyc = 0;
  always #2 clk = ~clk;
  adc_output_enable_power_modes #(.SLEEP_CYC(20), .NAP_CYC(8)) dut (
    .clk(clk), .rst(rst), .out_disable(dis), .power_down_select(sel),
    .conv_data(din), .conv_over(ovr), .data_o(d), .data_oe(oe),
    .overrange_flag_o(ov), .overrange_flag_oe(ov_oe),
    .sample_clock_out_o(sc), .sample_clock_out_oe(sc_oe),
    .reference_on(ref_on), .core_active(core), .data_valid(valid));
  capture_model cap (.sclk(sc), .data(d), .oe(oe[0]), .valid(valid),
    .word(word));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  task automatic pins(input logic s, input logic o, input int n);
    sel = s;
    dis = o;
    repeat (n) @(negedge clk);
  endtask : pins
  task automatic stop_test;
    $display("mismatches %0d of %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  // fresh word and flag reach pads and host
  task automatic t_data;
    logic prev;
    din = 12'h3c5;
    ovr = 1'b1;
    pins(0, 0, 4);
    chk(d, 12'h3c5);
    chk(12'(ov), 12'h001);
    chk(word, 12'h3c5);
    prev = sc;
    @(negedge clk);
    chk(12'(sc), {11'h000, ~prev});
    din = 12'h5a3;
    ovr = 1'b0;
  endtask : t_data
  task automatic t_nap;
    pins(1, 0, 3);
    chk(12'({ref_on, core, oe[0], sc_oe}), 12'h008);
    pins(0, 0, 3);
    chk(12'(valid), 12'h000);
    pins(0, 0, 12);
    chk(12'(valid), 12'h001);
  endtask : t_nap
  task automatic t_sleep;
    pins(1, 1, 3);
    chk(12'({ref_on, core, oe[0], ov_oe}), 12'h000);
    pins(0, 0, 12);
    chk(12'(valid), 12'h000);
    pins(0, 0, 14);
    chk(12'(valid), 12'h001);
  endtask : t_sleep
  // Reset, then enable, disable and both low-power exits
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    pins(0, 0, 8);
    chk(oe, 12'hfff);
    chk(word, 12'h5a3);
    t_data;
    pins(0, 1, 3);
    chk(12'({oe[0], ov_oe, sc_oe, core}), 12'h001);
    t_nap;
    t_sleep;
    stop_test;
  end
  // Hang guard well past the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      stop_test;
    end
  end
endmodule : adc_output_enable_power_modes_test
`default_nettype wire
